// ===== common/fault_supervisor_defs.vh
`ifndef FAULT_SUPERVISOR_DEFS_VH
`define FAULT_SUPERVISOR_DEFS_VH

// channel count and timeout
`define FS_NUM_CH          4
`define FS_TIMEOUT_CYCLES  6
`define FS_TIMEOUT_W       4
// channels already off by fault or exclusion that make a further short fatal
`define FS_SHUT_LIMIT      3
// supervisor state codes
`define FS_ST_OFF          2'h0
`define FS_ST_START        2'h1
`define FS_ST_RUN          2'h2
`define FS_ST_LATCH        2'h3

`endif

// ===== hw/pin_sync.v
`timescale 1ns/1ps
`default_nettype none

// two flip-flop synchroniser, one per bit
module pin_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_n_i,
	input  wire         ce_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);

	reg [W-1:0] meta;

	// first stage feeds only the second
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta <= {W{1'b0}};
			q_o  <= {W{1'b0}};
		end else if (ce_i) begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== hw/channel_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "fault_supervisor_defs.vh"

// per-channel fault timeout counted in dimming periods
module channel_timer #(
	parameter TIMEOUT = `FS_TIMEOUT_CYCLES
) (
	input  wire clk_i,
	input  wire rst_n_i,
	input  wire ce_i,
	input  wire fault_i,
	input  wire hold_i,
	input  wire pwm_edge_i,
	input  wire direct_pwm_i,
	output reg  expired_o
);

	reg [`FS_TIMEOUT_W-1:0] count;

	// count boundaries while fault persists, clear when it goes away
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			count     <= {`FS_TIMEOUT_W{1'b0}};
			expired_o <= 1'b0;
		end else if (ce_i) begin
			if (!fault_i) begin
				count <= {`FS_TIMEOUT_W{1'b0}};
			end else if (pwm_edge_i && !hold_i && !expired_o) begin
				if (count == TIMEOUT[`FS_TIMEOUT_W-1:0] - 4'h1) begin
					expired_o <= 1'b1;
				end else begin
					count <= count + 4'h1;
				end
			end
			// direct pwm: count clears only when fault is absent, as above, so timeout stays at six boundaries
			if (direct_pwm_i && !fault_i) begin
				count <= {`FS_TIMEOUT_W{1'b0}};
			end
		end
	end

endmodule

`default_nettype wire

// ===== hw/led_channel_fault_supervisor.v
// Contract
// - disable a channel staying over 8V above the lowest, after timeout
// - shorted channel switches off after six dimming periods of fault
// - direct PWM mode may stretch the timeout beyond six periods; the code keeps it at six periods
// - channel marked good at target; later drop means open, timed out
// - output overvoltage starts timeout for every channel not yet good
// - infinite open times out after six periods; others keep regulating
// - short with three channels already off shuts all channels down
// - short below threshold stays enabled, no fault
// - one channel fault leaves other channel enables untouched
// - grounded channel pin found at start-up and excluded
// - load transients hold fault timeouts until feedback is stable
// - low supply stops switching and resets to defaults
// - over-temperature stops boost and sinks, latched until reset
// - input overvoltage shuts down and latches until reset
// - enable low shuts the whole device down
// - output or switch node grounded at start-up blocks switching
`timescale 1ns/1ps
`default_nettype none
`include "fault_supervisor_defs.vh"

module led_channel_fault_supervisor #(
	parameter NUM_CH  = `FS_NUM_CH,
	parameter TIMEOUT = `FS_TIMEOUT_CYCLES
) (
	input  wire              clk_i,
	input  wire              rst_n_i,
	input  wire              ce_i,
	input  wire              enable_pin_i,
	input  wire              low_supply_lockout_i,
	input  wire              over_temp_i,
	input  wire              input_overvoltage_i,
	input  wire              output_overvoltage_limit_i,
	input  wire              output_grounded_i,
	input  wire              boost_switch_node_grounded_i,
	input  wire              transient_i,
	input  wire              feedback_stable_i,
	input  wire              direct_pwm_i,
	input  wire              pwm_period_i,
	input  wire [NUM_CH-1:0] short_voltage_threshold_i,
	input  wire [NUM_CH-1:0] at_target_i,
	input  wire [NUM_CH-1:0] pin_grounded_i,
	output reg  [NUM_CH-1:0] channel_enable_o,
	output reg               boost_enable_o,
	output reg               latched_off_o
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	localparam SW = NUM_CH * 3 + 12;

	wire [SW-1:0] raw_in;
	wire [SW-1:0] sync_in;

	assign raw_in = {short_voltage_threshold_i, at_target_i, pin_grounded_i,
		enable_pin_i, low_supply_lockout_i, over_temp_i, input_overvoltage_i,
		output_overvoltage_limit_i, output_grounded_i, boost_switch_node_grounded_i,
		transient_i, feedback_stable_i, direct_pwm_i, pwm_period_i, 1'b0};

	pin_sync #(
		.W (SW)
	) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.d_i     (raw_in),
		.q_o     (sync_in)
	);

	wire [NUM_CH-1:0] short_s;
	wire [NUM_CH-1:0] target_s;
	wire [NUM_CH-1:0] gnd_s;
	wire              en_s;
	wire              low_supply_lockout_s;
	wire              otp_s;
	wire              vin_ov_s;
	wire              ovp_s;
	wire              out_gnd_s;
	wire              sw_gnd_s;
	wire              trans_s;
	wire              stable_s;
	wire              direct_s;
	wire              pwm_s;
	wire              unused_s;

	assign {short_s, target_s, gnd_s, en_s, low_supply_lockout_s, otp_s, vin_ov_s, ovp_s,
		out_gnd_s, sw_gnd_s, trans_s, stable_s, direct_s, pwm_s, unused_s} = sync_in;

	////////////////////////////////////////////////////////////////////////
	// reset sources and dimming boundary

	reg  [1:0] state;
	reg        pwm_d;
	reg        hold;
	wire       soft_rst_n;
	wire       pwm_edge;

	// enable low or low supply returns everything but the synchroniser and pwm_d to defaults
	assign soft_rst_n = rst_n_i & en_s & ~low_supply_lockout_s;
	assign pwm_edge   = pwm_s & ~pwm_d;

	// rising edge of dimming period
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pwm_d <= 1'b0;
		end else if (ce_i) begin
			pwm_d <= pwm_s;
		end
	end

	// hold timeouts from a transient until feedback is stable
	always @(posedge clk_i) begin
		if (!soft_rst_n) begin
			hold <= 1'b0;
		end else if (ce_i) begin
			if (trans_s) begin
				hold <= 1'b1;
			end else if (stable_s) begin
				hold <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel good marks, fault detection and timers

	reg  [NUM_CH-1:0] good;
	reg  [NUM_CH-1:0] excluded;
	reg  [NUM_CH-1:0] faulted;
	reg  [NUM_CH-1:0] open_fault;
	wire [NUM_CH-1:0] fault_cond;
	wire [NUM_CH-1:0] expired;
	wire [NUM_CH-1:0] live;

	assign live = ~excluded & ~faulted;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
			// short comparator high only when over threshold; below it no fault
			assign fault_cond[g] = live[g] & (state == `FS_ST_RUN) &
				(short_s[g] | open_fault[g] | (ovp_s & ~good[g]));

			channel_timer #(
				.TIMEOUT (TIMEOUT)
			) u_timer (
				.clk_i        (clk_i),
				.rst_n_i      (soft_rst_n),
				.ce_i         (ce_i),
				.fault_i      (fault_cond[g]),
				.hold_i       (hold),
				.pwm_edge_i   (pwm_edge),
				.direct_pwm_i (direct_s),
				.expired_o    (expired[g])
			);

			// good once at target, open when a good channel drops
			always @(posedge clk_i) begin
				if (!soft_rst_n) begin
					good[g]       <= 1'b0;
					open_fault[g] <= 1'b0;
				end else if (ce_i) begin
					if (target_s[g]) begin
						good[g]       <= 1'b1;
						open_fault[g] <= 1'b0;
					end else if (good[g] && state == `FS_ST_RUN) begin
						open_fault[g] <= 1'b1;
					end
				end
			end

			// faulted channel latched off, touching no other channel
			always @(posedge clk_i) begin
				if (!soft_rst_n) begin
					faulted[g] <= 1'b0;
				end else if (ce_i && expired[g]) begin
					faulted[g] <= 1'b1;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// count of shut channels for the fatal short case

	reg [2:0] shut_count;
	integer   i;

	// channels already off by fault or exclusion
	always @* begin
		shut_count = 3'h0;
		for (i = 0; i < NUM_CH; i = i + 1) begin
			shut_count = shut_count + {2'h0, ~live[i]};
		end
	end

	wire new_short_expiry;

	assign new_short_expiry = |(expired & ~faulted & short_s);

	////////////////////////////////////////////////////////////////////////
	// supervisor state machine

	reg [1:0] next_state;

	// start-up screening, run, latched shutdown
	always @* begin
		next_state = state;
		case (state)
			`FS_ST_OFF: begin
				next_state = `FS_ST_START;
			end
			`FS_ST_START: begin
				if (!out_gnd_s && !sw_gnd_s) begin
					next_state = `FS_ST_RUN;
				end
			end
			`FS_ST_RUN: begin
				if (otp_s || vin_ov_s) begin
					next_state = `FS_ST_LATCH;
				end else if (new_short_expiry && shut_count >= `FS_SHUT_LIMIT) begin
					next_state = `FS_ST_LATCH;
				end
			end
			default: begin
				next_state = `FS_ST_LATCH;
			end
		endcase
		if (otp_s || vin_ov_s) begin
			next_state = `FS_ST_LATCH;
		end
	end

	always @(posedge clk_i) begin
		if (!soft_rst_n) begin
			state <= `FS_ST_OFF;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// grounded pins caught once at start-up and excluded
	always @(posedge clk_i) begin
		if (!soft_rst_n) begin
			excluded <= {NUM_CH{1'b0}};
		end else if (ce_i && state == `FS_ST_START) begin
			excluded <= gnd_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs

	always @(posedge clk_i) begin
		if (!soft_rst_n) begin
			channel_enable_o <= {NUM_CH{1'b0}};
			boost_enable_o   <= 1'b0;
			latched_off_o    <= 1'b0;
		end else if (ce_i) begin
			if (next_state == `FS_ST_RUN) begin
				// on entry from start-up the exclusion mask is not stored yet, so mask grounded pins here
				channel_enable_o <= live & ~expired &
					((state == `FS_ST_START) ? ~gnd_s : {NUM_CH{1'b1}});
				boost_enable_o   <= 1'b1;
			end else begin
				channel_enable_o <= {NUM_CH{1'b0}};
				boost_enable_o   <= 1'b0;
			end
			latched_off_o <= (next_state == `FS_ST_LATCH);
		end
	end

endmodule

`default_nettype wire

// ===== tb/led_supervisor_checker.sv
`timescale 1ns/1ps
`default_nettype none
module led_supervisor_checker #(
	parameter NUM_CH = 4
) (
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              enable_pin_i,
	input wire logic              low_supply_lockout_i,
	input wire logic              over_temp_i,
	input wire logic              input_overvoltage_i,
	input wire logic              output_grounded_i,
	input wire logic              transient_i,
	input wire logic              pwm_period_i,
	input wire logic [NUM_CH-1:0] short_voltage_threshold_i,
	input wire logic [NUM_CH-1:0] pin_grounded_i,
	input wire logic [NUM_CH-1:0] channel_enable_o,
	input wire logic              boost_enable_o,
	input wire logic              latched_off_o
);
	logic [3:0] cnt;
	logic       pwm_q;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// dimming edges seen while channel 0 is shorted
	always_ff @(posedge clk_i) begin
		pwm_q <= pwm_period_i;
		if (!rst_n_i || !short_voltage_threshold_i[0] || !channel_enable_o[0] || transient_i)
			cnt <= 4'h0;
		else if (pwm_period_i && !pwm_q)
			cnt <= cnt + 4'h1;
	end
	sequence shut_s;
		!boost_enable_o && channel_enable_o == '0;
	endsequence
	a_otp_latch: assert property ($rose(over_temp_i) && boost_enable_o |-> ##[2:5] shut_s ##0 latched_off_o)
		else $error("no latch after over-temperature");
	a_vin_latch: assert property ($rose(input_overvoltage_i) && boost_enable_o |-> ##[2:5] shut_s ##0 latched_off_o)
		else $error("no latch after input overvoltage");
	a_latch_hold: assert property (latched_off_o && enable_pin_i && $past(enable_pin_i, 3) |=> latched_off_o)
		else $error("latched shutdown released");
	a_enable_off: assert property (!enable_pin_i [*4] |=> shut_s)
		else $error("outputs live with enable low");
	a_lockout_off: assert property (low_supply_lockout_i [*4] |=> shut_s ##0 !latched_off_o)
		else $error("outputs live in supply lockout");
	a_no_reenable: assert property (boost_enable_o && $past(boost_enable_o) |-> (channel_enable_o & ~$past(channel_enable_o)) == '0)
		else $error("channel came back on");
	a_grounded_out: assert property ($rose(boost_enable_o) |-> (channel_enable_o & pin_grounded_i) == '0)
		else $error("grounded channel enabled");
	a_short_early: assert property ($fell(channel_enable_o[0]) && boost_enable_o |-> cnt >= 4'h5)
		else $error("short timeout too early");
	a_short_late: assert property (cnt == 4'h6 |-> ##[1:12] !channel_enable_o[0])
		else $error("short timeout too late");
	a_start_blocked: assert property (output_grounded_i |-> !$rose(boost_enable_o))
		else $error("boost started on grounded output");
endmodule
bind led_channel_fault_supervisor led_supervisor_checker #(.NUM_CH(NUM_CH)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.enable_pin_i(enable_pin_i), .low_supply_lockout_i(low_supply_lockout_i), .over_temp_i(over_temp_i),
	.input_overvoltage_i(input_overvoltage_i), .output_grounded_i(output_grounded_i), .transient_i(transient_i),
	.pwm_period_i(pwm_period_i), .short_voltage_threshold_i(short_voltage_threshold_i), .pin_grounded_i(pin_grounded_i),
	.channel_enable_o(channel_enable_o), .boost_enable_o(boost_enable_o), .latched_off_o(latched_off_o));
`default_nettype wire

// ===== tb/led_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_load_model #(
	parameter NUM_CH = 4
) (
	input wire logic [NUM_CH-1:0] channel_enable_i,
	input wire logic              boost_enable_i,
	input wire logic [NUM_CH-1:0] short_mask_i,
	input wire logic [NUM_CH-1:0] open_mask_i,
	output logic     [NUM_CH-1:0] short_o,
	output logic     [NUM_CH-1:0] at_target_o,
	output logic                  ovp_o
);
	// an enabled open string drives the boost output up to its limit
	assign ovp_o = boost_enable_i & |(channel_enable_i & open_mask_i);
	// a lit string reaches target unless open; a short shows only while lit
	assign short_o = short_mask_i & channel_enable_i;
	assign at_target_o = channel_enable_i & ~open_mask_i & {NUM_CH{boost_enable_i}};
endmodule
`default_nettype wire

// ===== tb/led_channel_fault_supervisor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module led_channel_fault_supervisor_tb;
	logic       clk = 1'b0, rst_n = 1'b0, en_pin = 1'b1, lock = 1'b0, otp = 1'b0, vovp = 1'b0;
	logic       gnd_out = 1'b0, trans = 1'b0, fb = 1'b1, pwm = 1'b0, boost, latched;
	logic [3:0] pin_gnd = 4'h0, sh_m = 4'h0, op_m = 4'h0, ch_en, sh, tgt;
	logic       ce = 1'b1, direct = 1'b0, sw_gnd = 1'b0, output_overvoltage_limit;
	int         num_errors = 0, checks_done = 0;
	always #50 clk = ~clk;
	led_channel_fault_supervisor dut (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .enable_pin_i(en_pin),
		.low_supply_lockout_i(lock), .over_temp_i(otp), .input_overvoltage_i(vovp), .output_overvoltage_limit_i(output_overvoltage_limit),
		.output_grounded_i(gnd_out), .boost_switch_node_grounded_i(sw_gnd), .transient_i(trans),
		.feedback_stable_i(fb), .direct_pwm_i(direct), .pwm_period_i(pwm), .short_voltage_threshold_i(sh),
		.at_target_i(tgt), .pin_grounded_i(pin_gnd), .channel_enable_o(ch_en), .boost_enable_o(boost),
		.latched_off_o(latched));
	led_load_model load (.channel_enable_i(ch_en), .boost_enable_i(boost), .short_mask_i(sh_m),
		.open_mask_i(op_m), .short_o(sh), .at_target_o(tgt), .ovp_o(output_overvoltage_limit));
	task cyc(input int n); repeat (n) @(posedge clk); endtask
	task pulses(input int n);
		repeat (n) begin
			pwm <= 1'b1; cyc(3); pwm <= 1'b0; cyc(3);
		end
	endtask
	task restart;
		rst_n <= 1'b0; en_pin <= 1'b1; lock <= 1'b0; otp <= 1'b0; vovp <= 1'b0;
		sh_m <= 4'h0; op_m <= 4'h0; trans <= 1'b0; fb <= 1'b1;
		cyc(4); rst_n <= 1'b1; cyc(8);
	endtask
	task t_short;
		restart; `CHK(ch_en, 4'hF)
		sh_m <= 4'h1; pulses(4); sh_m <= 4'h0; cyc(6);
		sh_m <= 4'h1; pulses(4); `CHK(ch_en, 4'hF)
		pulses(3); `CHK(ch_en, 4'hE)
		sh_m <= 4'h0; pulses(2); `CHK(ch_en, 4'hE)
	endtask
	task t_open;
		restart; op_m <= 4'h2; pulses(7);
		`CHK({boost, ch_en}, 5'h1D)
		// open from power-up: never good, so the output limit times it out
		op_m <= 4'h4; rst_n <= 1'b0; cyc(4); rst_n <= 1'b1; cyc(8); `CHK(ch_en, 4'hF)
		pulses(7); `CHK({boost, ch_en}, 5'h1B)
		op_m <= 4'h0;
	endtask
	task t_trans;
		restart; direct <= 1'b1; trans <= 1'b1; fb <= 1'b0; cyc(4);
		sh_m <= 4'h4; pulses(8); `CHK(ch_en, 4'hF)
		trans <= 1'b0; fb <= 1'b1; cyc(4); pulses(5); `CHK(ch_en, 4'hF)
		pulses(2); `CHK(ch_en, 4'hB)
		direct <= 1'b0;
	endtask
	task t_ground;
		pin_gnd <= 4'h8; restart; `CHK(ch_en, 4'h7)
		pin_gnd <= 4'hE; restart; `CHK(ch_en, 4'h1)
		sh_m <= 4'h1; pulses(7); `CHK({latched, boost, ch_en}, 6'h20)
		pin_gnd <= 4'h0;
	endtask
	task t_freeze;
		restart; ce <= 1'b0; sh_m <= 4'h8; pulses(8); `CHK(ch_en, 4'hF)
		ce <= 1'b1; sh_m <= 4'h0; cyc(6); `CHK(ch_en, 4'hF)
	endtask
	task t_latch;
		for (int i = 0; i < 2; i++) begin
			restart; otp <= (i == 0); vovp <= (i == 1); cyc(6);
			`CHK({latched, boost, ch_en}, 6'h20)
			en_pin <= 1'b0; cyc(6); `CHK(latched, 1'b0)
			otp <= 1'b0; vovp <= 1'b0; en_pin <= 1'b1; cyc(8);
			`CHK({latched, boost, ch_en}, 6'h1F)
		end
	endtask
	task t_low_supply_lockout;
		restart; sh_m <= 4'h1; pulses(7); lock <= 1'b1; cyc(6);
		`CHK({boost, ch_en}, 5'h00)
		lock <= 1'b0; sh_m <= 4'h0; cyc(8); `CHK({boost, ch_en}, 5'h1F)
	endtask
	task t_gnd_out;
		for (int i = 0; i < 2; i++) begin
			gnd_out <= (i == 0); sw_gnd <= (i == 1); restart; `CHK(boost, 1'b0)
			gnd_out <= 1'b0; sw_gnd <= 1'b0; cyc(8); `CHK(boost, 1'b1)
		end
	endtask
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		t_short; t_open; t_trans; t_ground; t_latch; t_low_supply_lockout; t_gnd_out; t_freeze;
		stop_test;
	end
	// watchdog, about thirty times the expected run of about 620 cycles
	initial begin
		#2000000;
		num_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
